// ### shared/eeprom_consts.vh
// Constants for the serial EEPROM command port: timing, opcodes,
// instruction lengths and reset values.
// Assumes a 125 MHz core clock; included by its bare name.
`ifndef EEPROM_CONSTS_VH
`define EEPROM_CONSTS_VH

// Core clock rate in MHz
`define CLK_MHZ 125
// Longest self-timed programming time in microseconds
`define PROG_TIME_US 5000
// Programming time in core cycles (longest time times clock rate)
`define PROG_CYCLES (`PROG_TIME_US * `CLK_MHZ)
// Least host wait before raising select for status, in ns
`define SELECT_LOW_WAIT_NS 200
// Cycles in one sweep of the whole byte array
`define SWEEP_CYCLES 1024

// Operation codes after the start bit
`define OP_SPECIAL 2'h0
`define OP_WRITE 2'h1
`define OP_READ 2'h2
`define OP_ERASE 2'h3

// Top address bits selecting a special instruction
`define SEL_PROGRAM_LOCK 2'h0
`define SEL_FILL_ARRAY 2'h1
`define SEL_CLEAR_ARRAY 2'h2
`define SEL_WRITE_ENABLE 2'h3

// Bits after the start bit (clock count less one)
`define LEN_BYTE_NODATA 5'h0d
`define LEN_BYTE_DATA 5'h15
`define LEN_WORD_NODATA 5'h0c
`define LEN_WORD_DATA 5'h1c

// Field positions inside the instruction shift register
`define OP_POS_BYTE 11
`define OP_POS_WORD 10
`define DATA_SHIFT_BYTE 8
`define DATA_SHIFT_WORD 16

// Reset values
`define WEN_RESET 1'b0
`define ERASED_BYTE 8'hff
`define ERASED_WORD 16'hffff

`endif

// ### core/word_buffer.v
// Two-entry word buffer with valid/ready on both sides and a flush.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps

module word_buffer
(
    input wire clk,
    input wire rst,
    input wire flush,
    input wire in_valid,
    output wire in_ready,
    input wire [15:0] in_data,
    output wire out_valid,
    input wire out_ready,
    output wire [15:0] out_data
);

    reg [15:0] entry_ff [0:1]; // Storage for the two words
    reg wr_ptr_ff; // Next entry to fill
    reg rd_ptr_ff; // Next entry to drain
    reg [1:0] count_ff; // Words held
    wire push; // Word accepted this cycle
    wire pop; // Word taken this cycle

    // Honest full and empty flags
    assign in_ready = (count_ff != 2'h2);
    assign out_valid = (count_ff != 2'h0);
    assign out_data = entry_ff[rd_ptr_ff];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Entry storage, written on push only
    always @(posedge clk)
    begin
        if (push)
        begin
            entry_ff[wr_ptr_ff] <= in_data;
        end
    end

    // Pointers and fill count
    always @(posedge clk)
    begin
        if (rst || flush)
        begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop)
            begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop)
            begin
                count_ff <= count_ff + 2'h1;
            end
            else if (pop && !push)
            begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end

endmodule // word_buffer

// ### core/serial_eeprom_command_port.v
// Serial command port and array of an 8-kbit EEPROM model.
// Assumes pins arrive asynchronously and are sampled by a 125 MHz
// core clock; the serial clock must be far slower than the core.
`timescale 1ns/1ps
`include "eeprom_consts.vh"

module serial_eeprom_command_port
#(
    parameter PROG_CYCLES = `PROG_CYCLES
)
(
    input wire clk,
    input wire rst,
    input wire chip_select,
    input wire serial_clock_in,
    input wire data_in,
    input wire width_strap,
    output wire data_out,
    output wire data_out_en,
    output wire write_enabled,
    output wire prog_busy
);

    // Decoder states
    localparam [1:0] ST_IDLE = 2'h0; // Waiting for start bit
    localparam [1:0] ST_SHIFT = 2'h1; // Collecting instruction bits
    localparam [1:0] ST_READ = 2'h2; // Streaming read data
    localparam [19:0] PROG_LAST = PROG_CYCLES[19:0] - 20'h00001; // End

    // Two-flop synchronisers for the pins
    reg [3:0] sync1_ff; // First stage, read only by the second
    reg [3:0] sync2_ff; // Second stage
    reg cs_d_ff; // Delayed select for edge finding
    reg sclk_d_ff; // Delayed serial clock for edge finding
    wire cs_s; // Synchronised select
    wire sclk_s; // Synchronised serial clock
    wire din_s; // Synchronised data input
    wire word_mode; // Word organisation chosen by the strap
    wire sclk_rise; // Rising serial clock seen
    wire cs_rise; // Select raised
    wire cs_fall; // Select dropped

    // Decoder state
    reg [1:0] state_ff; // Decoder state
    reg [27:0] sr_ff; // Instruction shift register
    reg [4:0] cnt_ff; // Bits after start, saturating
    reg wen_ff; // Write-enable latch
    reg [27:0] nxt_sr; // Shift register with new bit
    reg [4:0] nxt_cnt; // Count with new bit

    // Read stream state
    reg [9:0] rd_ptr_ff; // Next location to fetch
    reg fetch_ff; // Fetching into the buffer
    reg [15:0] shift_ff; // Output shift register
    reg [4:0] bits_ff; // Bits left in the current word
    reg rbit_ff; // Current read bit
    reg status_ff; // Ready/busy shown on the output
    reg dout_ff; // Registered output level

    // Programming state
    reg busy_ff; // Self-timed cycle in progress
    reg [19:0] prog_cnt_ff; // Cycle counter of the busy time
    reg [1:0] pop_ff; // Latched operation kind
    reg all_ff; // Whole-array operation
    reg [9:0] paddr_ff; // Latched target location
    reg [15:0] pdata_ff; // Latched data pattern

    // Array of 1024 bytes
    reg [7:0] mem [0:1023];

    // Decoded fields
    wire [1:0] op_len; // Opcode when length ends at address
    wire [1:0] op_dat; // Opcode when a data field is present
    wire [10:0] addr_len; // Address field, no-data form
    wire [10:0] addr_dat; // Address field, data form
    wire [15:0] data_fld; // Data field
    wire [1:0] sel_len; // Special select, no-data form
    wire [1:0] sel_dat; // Special select, data form
    wire len_nodata; // Count matches a no-data instruction
    wire len_data; // Count matches a data instruction
    wire [1:0] rd_op; // Opcode seen at the read decode point
    wire [4:0] addr_end; // Count at which the address is complete
    wire do_prog; // Programming accepted at select fall
    wire [1:0] do_kind; // Kind of programming accepted
    wire do_all; // Whole-array programming accepted
    wire [15:0] do_data; // Pattern to program

    // Buffer signals
    wire [15:0] fetch_word; // Word at the fetch pointer
    wire buf_in_ready; // Buffer can take a word
    wire buf_out_valid; // Buffer holds a word
    wire [15:0] buf_out; // Oldest buffered word
    wire want_word; // Output shifter takes a word
    wire buf_flush; // Clear buffered words
    wire [9:0] next_ptr; // Fetch pointer after one step
    wire sweep_on; // Array sweep active
    wire [9:0] idx; // Sweep index
    wire hit; // Sweep index is a target
    wire [7:0] wbyte; // Byte written at the sweep index

    // Pin sampling through two flops each
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1_ff <= 4'h0;
            sync2_ff <= 4'h0;
            cs_d_ff <= 1'b0;
            sclk_d_ff <= 1'b0;
        end
        else
        begin
            sync1_ff <= {width_strap, data_in, serial_clock_in,
                chip_select};
            sync2_ff <= sync1_ff;
            cs_d_ff <= sync2_ff[0];
            sclk_d_ff <= sync2_ff[1];
        end
    end

    assign cs_s = sync2_ff[0];
    assign sclk_s = sync2_ff[1];
    assign din_s = sync2_ff[2];
    assign word_mode = sync2_ff[3];
    // Serial clock edges only while selected; static clock gives no edge
    assign sclk_rise = sclk_s && !sclk_d_ff && cs_s;
    assign cs_rise = cs_s && !cs_d_ff;
    assign cs_fall = !cs_s && cs_d_ff;

    // Shift register with the newly sampled bit
    always @*
    begin
        nxt_sr = {sr_ff[26:0], din_s};
        nxt_cnt = (cnt_ff == 5'h1f) ? cnt_ff : cnt_ff + 5'h01;
    end

    // Field positions depend on organisation
    assign addr_end = word_mode ? `LEN_WORD_NODATA : `LEN_BYTE_NODATA;
    assign rd_op = word_mode ? nxt_sr[`OP_POS_WORD +: 2] :
        nxt_sr[`OP_POS_BYTE +: 2];
    assign op_len = word_mode ? sr_ff[`OP_POS_WORD +: 2] :
        sr_ff[`OP_POS_BYTE +: 2];
    assign op_dat = word_mode ? sr_ff[`OP_POS_WORD + 16 +: 2] :
        sr_ff[`OP_POS_BYTE + 8 +: 2];
    assign addr_len = word_mode ? {1'b0, sr_ff[9:0]} : sr_ff[10:0];
    assign addr_dat = word_mode ? {1'b0, sr_ff[25:16]} : sr_ff[18:8];
    assign data_fld = word_mode ? sr_ff[15:0] : {8'h00, sr_ff[7:0]};
    assign sel_len = word_mode ? addr_len[9:8] : addr_len[10:9];
    assign sel_dat = word_mode ? addr_dat[9:8] : addr_dat[10:9];
    // Exact clock counts only
    assign len_nodata = (state_ff == ST_SHIFT) &&
        (cnt_ff == addr_end);
    assign len_data = (state_ff == ST_SHIFT) && (cnt_ff ==
        (word_mode ? `LEN_WORD_DATA : `LEN_BYTE_DATA));

    // Programming accepted at select fall: write, fill, erase, clear
    assign do_prog = cs_fall && wen_ff && !busy_ff && (
        (len_data && op_dat == `OP_WRITE) ||
        (len_data && op_dat == `OP_SPECIAL &&
            sel_dat == `SEL_FILL_ARRAY) ||
        (len_nodata && op_len == `OP_ERASE) ||
        (len_nodata && op_len == `OP_SPECIAL &&
            sel_len == `SEL_CLEAR_ARRAY));
    assign do_kind = len_data ? op_dat : op_len;
    assign do_all = len_data ? (op_dat == `OP_SPECIAL) :
        (op_len == `OP_SPECIAL);
    // Erase forms program ones
    assign do_data = len_data ? data_fld : `ERASED_WORD;

    // Instruction decoder and write-enable latch
    always @(posedge clk)
    begin
        if (rst)
        begin
            state_ff <= ST_IDLE;
            sr_ff <= 28'h0000000;
            cnt_ff <= 5'h00;
            wen_ff <= `WEN_RESET;
        end
        else if (cs_fall)
        begin
            // Abort anything partial and return to standby
            state_ff <= ST_IDLE;
            cnt_ff <= 5'h00;
            if (len_nodata && op_len == `OP_SPECIAL)
            begin
                if (sel_len == `SEL_WRITE_ENABLE)
                begin
                    wen_ff <= 1'b1;
                end
                else if (sel_len == `SEL_PROGRAM_LOCK)
                begin
                    wen_ff <= 1'b0;
                end
            end
        end
        else if (sclk_rise)
        begin
            case (state_ff)
                ST_IDLE:
                begin
                    // Leading zeros skipped; busy ignores start
                    if (din_s && !busy_ff)
                    begin
                        state_ff <= ST_SHIFT;
                        cnt_ff <= 5'h00;
                    end
                end
                ST_SHIFT:
                begin
                    sr_ff <= nxt_sr;
                    cnt_ff <= nxt_cnt;
                    // Read acts as soon as its address is in
                    if (nxt_cnt == addr_end && rd_op == `OP_READ)
                    begin
                        state_ff <= ST_READ;
                    end
                end
                ST_READ:
                begin
                    // Stream continues until select falls
                    state_ff <= ST_READ;
                end
                default:
                begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // Fetch side of the read path
    assign fetch_word = word_mode ?
        {mem[{rd_ptr_ff[8:0], 1'b0}], mem[{rd_ptr_ff[8:0], 1'b1}]} :
        {mem[rd_ptr_ff], 8'h00};
    // Wrap from top location back to zero
    assign next_ptr = word_mode ? {1'b0, rd_ptr_ff[8:0] + 9'h001} :
        rd_ptr_ff + 10'h001;
    assign buf_flush = cs_fall || (state_ff != ST_READ);
    assign want_word = sclk_rise && (state_ff == ST_READ) &&
        (bits_ff == 5'h00);

    // Fetch pointer, advanced on each accepted word
    always @(posedge clk)
    begin
        if (rst || cs_fall)
        begin
            rd_ptr_ff <= 10'h000;
            fetch_ff <= 1'b0;
        end
        else if (sclk_rise && state_ff == ST_SHIFT &&
            nxt_cnt == addr_end && rd_op == `OP_READ)
        begin
            rd_ptr_ff <= word_mode ? {1'b0, nxt_sr[8:0]} : nxt_sr[9:0];
            fetch_ff <= 1'b1;
        end
        else if (fetch_ff && buf_in_ready && state_ff == ST_READ)
        begin
            rd_ptr_ff <= next_ptr;
        end
    end

    // Buffer between array fetch and output shifter
    word_buffer u_word_buffer
    (
        .clk(clk),
        .rst(rst),
        .flush(buf_flush),
        .in_valid(fetch_ff && state_ff == ST_READ),
        .in_ready(buf_in_ready),
        .in_data(fetch_word),
        .out_valid(buf_out_valid),
        .out_ready(want_word),
        .out_data(buf_out)
    );

    // Output shifter: dummy zero, then words MSB first
    always @(posedge clk)
    begin
        if (rst || cs_fall)
        begin
            shift_ff <= 16'h0000;
            bits_ff <= 5'h00;
            rbit_ff <= 1'b0;
        end
        else if (sclk_rise && state_ff == ST_SHIFT)
        begin
            // Dummy bit sits on the pin after the address
            rbit_ff <= 1'b0;
            bits_ff <= 5'h00;
        end
        else if (sclk_rise && state_ff == ST_READ)
        begin
            if (bits_ff == 5'h00)
            begin
                if (buf_out_valid)
                begin
                    rbit_ff <= buf_out[15];
                    shift_ff <= {buf_out[14:0], 1'b0};
                    bits_ff <= word_mode ? 5'h0f : 5'h07;
                end
            end
            else
            begin
                rbit_ff <= shift_ff[15];
                shift_ff <= {shift_ff[14:0], 1'b0};
                bits_ff <= bits_ff - 5'h01;
            end
        end
    end

    // Self-timed programming timer
    always @(posedge clk)
    begin
        if (rst)
        begin
            busy_ff <= 1'b0;
            prog_cnt_ff <= 20'h00000;
            pop_ff <= 2'h0;
            all_ff <= 1'b0;
            paddr_ff <= 10'h000;
            pdata_ff <= 16'h0000;
        end
        else if (do_prog)
        begin
            busy_ff <= 1'b1;
            prog_cnt_ff <= 20'h00000;
            pop_ff <= do_kind;
            all_ff <= do_all;
            paddr_ff <= len_data ? addr_dat[9:0] : addr_len[9:0];
            pdata_ff <= do_data;
        end
        else if (busy_ff)
        begin
            if (prog_cnt_ff == PROG_LAST)
            begin
                busy_ff <= 1'b0;
            end
            else
            begin
                prog_cnt_ff <= prog_cnt_ff + 20'h00001;
            end
        end
    end

    // Sweep over every byte early in the busy time
    assign sweep_on = busy_ff && (prog_cnt_ff < `SWEEP_CYCLES);
    assign idx = prog_cnt_ff[9:0];
    // One byte or word, or all of them
    assign hit = all_ff || (word_mode ? (idx[9:1] == paddr_ff[8:0]) :
        (idx == paddr_ff));
    assign wbyte = word_mode ? (idx[0] ? pdata_ff[7:0] :
        pdata_ff[15:8]) : pdata_ff[7:0];

    // Array write; the new value replaces the old outright
    always @(posedge clk)
    begin
        if (sweep_on && hit)
        begin
            mem[idx] <= wbyte;
        end
    end

    // Ready/busy status on select rise while still programming
    always @(posedge clk)
    begin
        if (rst || cs_fall)
        begin
            status_ff <= 1'b0;
        end
        else if (cs_rise && busy_ff)
        begin
            status_ff <= 1'b1;
        end
        else if (sclk_rise && din_s && !busy_ff)
        begin
            status_ff <= 1'b0;
        end
    end

    // Registered output level
    always @(posedge clk)
    begin
        if (rst)
        begin
            dout_ff <= 1'b0;
        end
        else if (status_ff)
        begin
            dout_ff <= !busy_ff;
        end
        else
        begin
            dout_ff <= rbit_ff;
        end
    end

    assign data_out = dout_ff;
    // Released whenever select is low
    assign data_out_en = cs_s && (status_ff || state_ff == ST_READ);
    assign write_enabled = wen_ff;
    assign prog_busy = busy_ff;

endmodule // serial_eeprom_command_port

// ### verif/eeprom_port_sva.sv
// Checker for the serial EEPROM command port, watching its ports only.
// Assumes one 125 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps

module eeprom_port_sva
#(
    parameter PROG_CYCLES = 2000
)
(
    input wire clk,
    input wire rst,
    input wire chip_select,
    input wire serial_clock_in,
    input wire data_in,
    input wire width_strap,
    input wire data_out,
    input wire data_out_en,
    input wire write_enabled,
    input wire prog_busy
);
    // Cycles spent in the current programming run
    reg [31:0] busy_cnt_ff;

    // Count busy cycles, clear when idle
    always @(posedge clk)
    begin
        if (rst || !prog_busy)
            busy_cnt_ff <= 32'h0;
        else
            busy_cnt_ff <= busy_cnt_ff + 32'h1;
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_rst_quiet;
        disable iff (1'b0)
        rst |=> !data_out_en && !write_enabled && !prog_busy;
    endproperty
    property p_cs_low_hiz;
        !chip_select [*4] |-> !data_out_en;
    endproperty
    property p_busy_bound;
        prog_busy |-> busy_cnt_ff < PROG_CYCLES + 2;
    endproperty
    property p_wen_change;
        $changed(write_enabled) |-> !$past(chip_select);
    endproperty
    property p_busy_start;
        $rose(prog_busy) |-> write_enabled && !chip_select;
    endproperty
    property p_status_busy;
        prog_busy && data_out_en ##1 prog_busy |-> !$past(data_out);
    endproperty
    property p_ready_shows;
        $fell(prog_busy) && data_out_en |-> ##[0:2] data_out;
    endproperty
    property p_oe_rise;
        $rose(data_out_en) |-> $past(chip_select, 2) &&
            (prog_busy || $past(serial_clock_in, 3));
    endproperty

    a_rst_quiet: assert property (p_rst_quiet)
        else $error("outputs not quiet after reset");
    a_cs_low_hiz: assert property (p_cs_low_hiz)
        else $error("output driven while deselected");
    a_busy_bound: assert property (p_busy_bound)
        else $error("programming runs too long");
    a_wen_change: assert property (p_wen_change)
        else $error("enable changed while selected");
    a_busy_start: assert property (p_busy_start)
        else $error("programming started without enable or select fall");
    a_status_busy: assert property (p_status_busy)
        else $error("status shows ready while busy");
    a_ready_shows: assert property (p_ready_shows)
        else $error("status missed ready");
    a_oe_rise: assert property (p_oe_rise)
        else $error("output enable rose without cause");

    c_status: cover property (prog_busy && data_out_en);
    c_read: cover property (data_out_en && !prog_busy && data_out);
    c_wen: cover property ($rose(write_enabled));
endmodule // eeprom_port_sva

// ### verif/host_model.sv
// Host controller model driving select, serial clock and data in.
// Assumes the bench clock; serial clock period is 20 core cycles.
`timescale 1ns/1ps

module host_model
(
    input wire clk,
    input wire data_out,
    input wire data_out_en,
    output reg chip_select,
    output reg serial_clock_in,
    output reg data_in
);
    // Last level the device drove onto the pin
    reg last_ff = 1'b0;
    // Pin as the host sees it; a released pin drifts away
    wire pin;

    assign pin = data_out_en ? data_out : ~last_ff;

    // Remember the driven level
    always @(posedge clk)
    begin
        if (data_out_en)
            last_ff <= data_out;
    end

    // Idle pins at time zero, serial clock parked low
    initial
    begin
        chip_select = 1'b0;
        serial_clock_in = 1'b0;
        data_in = 1'b0;
    end

    // Shift n bits MSB first, then rd more clocks sampling the pin
    task xfer(input [31:0] bits, input integer n, input integer rd,
        output [31:0] got);
        integer i;
        begin
            got = 32'h0;
            @(posedge clk);
            chip_select <= 1'b1;
            for (i = n - 1; i >= -rd; i = i - 1)
            begin
                data_in <= (i >= 0) ? bits[i] : ~data_in;
                repeat (10) @(posedge clk);
                got = {got[30:0], pin};
                serial_clock_in <= 1'b1;
                repeat (10) @(posedge clk);
                serial_clock_in <= 1'b0;
            end
            @(posedge clk);
            chip_select <= 1'b0;
            data_in <= ~data_in;
            repeat (6) @(posedge clk);
        end
    endtask

    // Select without clocking, for status
    task cs_up;
        begin
            @(posedge clk);
            chip_select <= 1'b1;
        end
    endtask

    task cs_down;
        begin
            @(posedge clk);
            chip_select <= 1'b0;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule // host_model

// ### verif/serial_eeprom_command_port_bench.sv
// Self-checking bench for the serial EEPROM command port.
// Assumes host_model and eeprom_port_sva are compiled first.
`timescale 1ns/1ps

`define CHECK(g, e) begin compares = compares + 1; if ((g) !== (e)) \
begin fails = fails + 1; \
$display("[FAIL] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module serial_eeprom_command_port_bench;
    reg clk = 1'b0;
    reg rst = 1'b1;
    reg width_strap = 1'b0; // Byte organisation first
    wire chip_select;
    wire serial_clock_in;
    wire data_in;
    wire data_out;
    wire data_out_en;
    wire write_enabled;
    wire prog_busy;
    reg [31:0] rx; // Samples returned by a read
    integer fails = 0;
    integer compares = 0;

    // 125 MHz core clock
    always #4 clk = ~clk;

    serial_eeprom_command_port #(.PROG_CYCLES(2000)) dut (
        .clk(clk), .rst(rst), .chip_select(chip_select),
        .serial_clock_in(serial_clock_in), .data_in(data_in),
        .width_strap(width_strap), .data_out(data_out),
        .data_out_en(data_out_en), .write_enabled(write_enabled),
        .prog_busy(prog_busy));

    host_model host (
        .clk(clk), .data_out(data_out), .data_out_en(data_out_en),
        .chip_select(chip_select), .serial_clock_in(serial_clock_in),
        .data_in(data_in));

    task report_and_stop;
        begin
            $display("compares=%0d fails=%0d", compares, fails);
            if (fails == 0 && compares > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    // Follow one programming run; look raises select while busy
    task prog_done(input reg look);
        integer k;
        begin
            repeat (30) @(posedge clk);
            `CHECK(prog_busy, 1'b1)
            if (look)
            begin
                host.cs_up();
                repeat (8) @(posedge clk);
                `CHECK(host.pin, 1'b0)
            end
            k = 0;
            while (prog_busy !== 1'b0 && k < 3000)
            begin
                @(posedge clk);
                k = k + 1;
            end
            `CHECK(prog_busy, 1'b0)
            if (!look)
                host.cs_up();
            repeat (6) @(posedge clk);
            `CHECK(data_out_en, look)
            if (look)
                `CHECK(host.pin, 1'b1)
            host.cs_down();
        end
    endtask

    // Give up if the run hangs
    initial
    begin
        repeat (60000) @(posedge clk);
        fails = fails + 1;
        report_and_stop;
    end

    // Main test sequence
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        `CHECK(write_enabled, 1'b0)
        `CHECK(data_out_en, 1'b0)
        host.xfer(32'h28053c, 22, 0, rx);
        repeat (10) @(posedge clk);
        `CHECK(prog_busy, 1'b0)
        $display("test locked_write done");
        host.xfer(32'h2600, 14, 0, rx);
        `CHECK(write_enabled, 1'b1)
        host.xfer(32'h2200a5, 22, 0, rx);
        prog_done(1'b1);
        host.xfer(32'h28005a, 22, 0, rx);
        prog_done(1'b1);
        host.xfer(32'h2803c3, 22, 0, rx);
        prog_done(1'b0);
        host.xfer(32'h33ff, 14, 17, rx);
        `CHECK(rx[16:0], 17'h0a55a)
        host.xfer(32'h3002, 14, 25, rx);
        `CHECK(rx[24:0], 25'h0a5c3a5)
        $display("test fill_write_read done");
        host.xfer(32'h3803, 14, 0, rx);
        prog_done(1'b1);
        host.xfer(32'h3002, 14, 25, rx);
        `CHECK(rx[24:0], 25'h0a5ffa5)
        $display("test erase done");
        host.xfer(32'h280, 10, 0, rx);
        repeat (10) @(posedge clk);
        `CHECK(prog_busy, 1'b0)
        host.xfer(32'h140077, 21, 0, rx);
        repeat (10) @(posedge clk);
        `CHECK(prog_busy, 1'b0)
        host.xfer(32'h3000, 14, 9, rx);
        `CHECK(rx[8:0], 9'h05a)
        $display("test abort done");
        host.xfer(32'h2000, 14, 0, rx);
        `CHECK(write_enabled, 1'b0)
        host.xfer(32'h280011, 22, 0, rx);
        repeat (10) @(posedge clk);
        `CHECK(prog_busy, 1'b0)
        host.xfer(32'h2600, 14, 0, rx);
        host.xfer(32'h2400, 14, 0, rx);
        prog_done(1'b1);
        host.xfer(32'h3000, 14, 9, rx);
        `CHECK(rx[8:0], 9'h0ff)
        $display("test lock_clear done");
        @(posedge clk);
        width_strap <= 1'b1;
        repeat (6) @(posedge clk);
        host.xfer(32'h1300, 13, 0, rx);
        host.xfer(32'h15ff1234, 29, 0, rx);
        prog_done(1'b1);
        host.xfer(32'h19ff, 13, 33, rx);
        `CHECK(rx, 32'h1234ffff)
        host.xfer(32'h1000, 13, 0, rx);
        `CHECK(write_enabled, 1'b0)
        $display("test word_mode done");
        report_and_stop;
    end
endmodule // serial_eeprom_command_port_bench

bind serial_eeprom_command_port eeprom_port_sva #(
    .PROG_CYCLES(PROG_CYCLES)) u_sva (
    .clk(clk), .rst(rst), .chip_select(chip_select),
    .serial_clock_in(serial_clock_in), .data_in(data_in),
    .width_strap(width_strap), .data_out(data_out),
    .data_out_en(data_out_en), .write_enabled(write_enabled),
    .prog_busy(prog_busy));
